// *** bpsf_pkg.sv ***
// Constants for the primary-side status flag bank
package bpsf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] PRIMARY_SIDE_STATUS_ADDR = 8'h04;
  // Bit positions within the 32-bit configuration word
  localparam int CAP_LIST_BIT = 20;
  localparam int HIGH_SPEED_BIT = 21;
  localparam int RSVD22_BIT = 22;
  localparam int B2B_BIT = 23;
  localparam int MDPE_BIT = 24;
  localparam int SEL_LO_BIT = 25;
  localparam int SEL_HI_BIT = 26;
  localparam int STA_BIT = 27;
  localparam int RTA_BIT = 28;
  localparam int RMA_BIT = 29;
  localparam int SSE_BIT = 30;
  localparam int DPE_BIT = 31;
  // Index of each flag inside the sticky flag vector
  localparam int NUM_FLAGS = 6;
  localparam int F_MDPE = 0;
  localparam int F_STA = 1;
  localparam int F_RTA = 2;
  localparam int F_RMA = 3;
  localparam int F_SSE = 4;
  localparam int F_DPE = 5;
  // Reset values and fixed field codes
  localparam logic CAP_LIST_VAL = 1'b1;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 6'h00;
  localparam logic [1:0] SEL_TIMING_FAST = 2'h0;
  localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
  localparam logic [1:0] SEL_TIMING_SLOW = 2'h2;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
  localparam logic PIN_IDLE = 1'b1;
endpackage : bpsf_pkg

// *** bpsf_status.sv ***
// Primary-side status half-word of the bridge configuration header
`timescale 1ns/10ps
`default_nettype none
module bpsf_status (
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [bpsf_pkg::ADDR_W-1:0] addr,
  input wire logic [bpsf_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [bpsf_pkg::DATA_W-1:0] rdata,
  // Straps and the parity error input from pins
  input wire logic reverse_mode_pin,
  input wire logic pci_mode_pin,
  input wire logic primary_parity_error_n,
  // Command register enables
  input wire logic parity_resp_en,
  // Forward mode events
  input wire logic fwd_poisoned_cpl_rx,
  input wire logic fwd_poisoned_wr_tx,
  input wire logic fwd_abort_cpl_tx,
  input wire logic fwd_abort_cpl_rx,
  input wire logic fwd_unsupp_cpl_rx,
  input wire logic fwd_err_msg_tx,
  input wire logic fwd_poisoned_tlp_rx,
  // Reverse mode events
  input wire logic rev_read_parity_err,
  input wire logic rev_sending_data,
  input wire logic rev_split_msg_parity_err,
  input wire logic rev_target_abort_tx,
  input wire logic rev_target_abort_rx,
  input wire logic rev_master_abort_rx,
  input wire logic rev_serr_asserted,
  input wire logic rev_parity_err_det,
  // Captured mode
  output logic reverse_mode
);
  import bpsf_pkg::*;

  logic rev_s1;
  logic rev_s2;
  logic pci_s1;
  logic pci_s2;
  logic perr_s1;
  logic perr_s2;
  logic pci_mode;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] set_ev;
  logic [NUM_FLAGS-1:0] clr_ev;
  logic status_hit;
  logic high_speed_capable;
  logic back_to_back_capable;
  logic [1:0] select_timing_code;
  logic [15:0] status_half;
  logic perr_on_send;

  // Strap synchronisers, free running so reset sees the pins
  always_ff @(posedge clk) begin
    rev_s1 <= reverse_mode_pin;
    rev_s2 <= rev_s1;
    pci_s1 <= pci_mode_pin;
    pci_s2 <= pci_s1;
  end

  // Parity error pin synchroniser, idles high
  always_ff @(posedge clk) begin
    if (srst) begin
      perr_s1 <= PIN_IDLE;
      perr_s2 <= PIN_IDLE;
    end else begin
      perr_s1 <= primary_parity_error_n;
      perr_s2 <= perr_s1;
    end
  end

  // Mode straps caught while reset is held, frozen afterwards
  always_ff @(posedge clk) begin
    if (srst) begin
      reverse_mode <= rev_s2;
      pci_mode <= pci_s2;
    end
  end

  // Read-only mode-dependent fields
  always_comb begin
    high_speed_capable = reverse_mode;
    back_to_back_capable = reverse_mode & pci_mode;
    if (reverse_mode) begin
      select_timing_code = SEL_TIMING_MEDIUM;
    end else begin
      select_timing_code = SEL_TIMING_FAST;
    end
  end

  assign perr_on_send = ~perr_s2 & rev_sending_data;

  // Set conditions per flag, selected by mode
  always_comb begin
    set_ev = '0;
    if (reverse_mode) begin
      set_ev[F_MDPE] = parity_resp_en &
        (rev_read_parity_err | perr_on_send |
         rev_split_msg_parity_err);
      set_ev[F_STA] = rev_target_abort_tx;
      set_ev[F_RTA] = rev_target_abort_rx;
      set_ev[F_RMA] = rev_master_abort_rx;
      set_ev[F_SSE] = rev_serr_asserted;
      set_ev[F_DPE] = rev_parity_err_det;
    end else begin
      set_ev[F_MDPE] = parity_resp_en &
        (fwd_poisoned_cpl_rx | fwd_poisoned_wr_tx);
      set_ev[F_STA] = fwd_abort_cpl_tx;
      set_ev[F_RTA] = fwd_abort_cpl_rx;
      set_ev[F_RMA] = fwd_unsupp_cpl_rx;
      set_ev[F_SSE] = fwd_err_msg_tx;
      set_ev[F_DPE] = fwd_poisoned_tlp_rx;
    end
  end

  assign status_hit = (addr == PRIMARY_SIDE_STATUS_ADDR);

  // Write-one-to-clear strobes
  always_comb begin
    clr_ev = '0;
    if (wr && status_hit) begin
      clr_ev[F_MDPE] = wdata[MDPE_BIT];
      clr_ev[F_STA] = wdata[STA_BIT];
      clr_ev[F_RTA] = wdata[RTA_BIT];
      clr_ev[F_RMA] = wdata[RMA_BIT];
      clr_ev[F_SSE] = wdata[SSE_BIT];
      clr_ev[F_DPE] = wdata[DPE_BIT];
    end
  end

  // Sticky flags, a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge clk) begin
        if (srst) begin
          flags[gi] <= FLAGS_RST[gi];
        end else begin
          flags[gi] <= set_ev[gi] | (flags[gi] & ~clr_ev[gi]);
        end
      end
    end
  endgenerate

  // Upper half-word as read; reserved bits fixed at zero
  always_comb begin
    status_half = '0;
    status_half[CAP_LIST_BIT-16] = CAP_LIST_VAL;
    status_half[HIGH_SPEED_BIT-16] = high_speed_capable;
    status_half[B2B_BIT-16] = back_to_back_capable;
    status_half[MDPE_BIT-16] = flags[F_MDPE];
    status_half[SEL_HI_BIT-16:SEL_LO_BIT-16] = select_timing_code;
    status_half[STA_BIT-16] = flags[F_STA];
    status_half[RTA_BIT-16] = flags[F_RTA];
    status_half[RMA_BIT-16] = flags[F_RMA];
    status_half[SSE_BIT-16] = flags[F_SSE];
    status_half[DPE_BIT-16] = flags[F_DPE];
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= RDATA_RST;
    end else if (rd && status_hit) begin
      rdata <= {status_half, 16'h0000};
    end else begin
      rdata <= RDATA_RST;
    end
  end

  // Checks
  property p_cap_list;
    @(posedge clk) disable iff (srst)
    rd && status_hit |=> rdata[CAP_LIST_BIT];
  endproperty
  a_cap_list: assert property (p_cap_list)
    else $error("capability list bit not one");

  property p_mode_bits;
    @(posedge clk) disable iff (srst)
    rd && status_hit |=> rdata[HIGH_SPEED_BIT] == reverse_mode &&
      rdata[B2B_BIT] == (reverse_mode & pci_mode);
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("mode dependent capability bits wrong");

  property p_timing;
    @(posedge clk) disable iff (srst)
    rd && status_hit |=> rdata[SEL_HI_BIT:SEL_LO_BIT] ==
      (reverse_mode ? SEL_TIMING_MEDIUM : SEL_TIMING_FAST);
  endproperty
  a_timing: assert property (p_timing)
    else $error("select timing code wrong");

  property p_reserved;
    @(posedge clk) disable iff (srst)
    rd |=> rdata[19:16] == 4'h0 && !rdata[RSVD22_BIT] &&
      rdata[15:0] == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_mdpe_gate;
    @(posedge clk) disable iff (srst)
    !parity_resp_en && !flags[F_MDPE] |=> !flags[F_MDPE];
  endproperty
  a_mdpe_gate: assert property (p_mdpe_gate)
    else $error("parity flag set while response disabled");

  property p_fwd_mdpe;
    @(posedge clk) disable iff (srst)
    !reverse_mode && parity_resp_en &&
      (fwd_poisoned_cpl_rx || fwd_poisoned_wr_tx)
      |=> flags[F_MDPE] && !(wr && status_hit && wdata[MDPE_BIT])
      ##1 rd && status_hit |=> rdata[MDPE_BIT];
  endproperty
  a_fwd_mdpe: assert property (p_fwd_mdpe)
    else $error("forward parity flag not set");

  property p_rev_mdpe;
    @(posedge clk) disable iff (srst)
    reverse_mode && parity_resp_en &&
      (rev_read_parity_err || rev_split_msg_parity_err)
      |=> flags[F_MDPE];
  endproperty
  a_rev_mdpe: assert property (p_rev_mdpe)
    else $error("reverse parity flag not set");

  property p_perr_pin;
    @(posedge clk) disable iff (srst)
    reverse_mode && parity_resp_en && rev_sending_data &&
      !perr_s2 |=> flags[F_MDPE];
  endproperty
  a_perr_pin: assert property (p_perr_pin)
    else $error("parity pin event lost");

  property p_fwd_aborts;
    @(posedge clk) disable iff (srst)
    !reverse_mode |-> (fwd_abort_cpl_tx |=> flags[F_STA]) and
      (fwd_abort_cpl_rx |=> flags[F_RTA]) and
      (fwd_unsupp_cpl_rx |=> flags[F_RMA]);
  endproperty
  a_fwd_aborts: assert property (p_fwd_aborts)
    else $error("forward abort flags not set");

  property p_rev_aborts;
    @(posedge clk) disable iff (srst)
    reverse_mode |-> (rev_target_abort_tx |=> flags[F_STA]) and
      (rev_serr_asserted |=> flags[F_SSE]) and
      (rev_parity_err_det |=> flags[F_DPE]);
  endproperty
  a_rev_aborts: assert property (p_rev_aborts)
    else $error("reverse event did not set its flag");

  property p_dpe_any;
    @(posedge clk) disable iff (srst)
    !reverse_mode && fwd_poisoned_tlp_rx
      ##1 !(wr && status_hit && wdata[DPE_BIT])
      ##1 rd && status_hit |=> rdata[DPE_BIT];
  endproperty
  a_dpe_any: assert property (p_dpe_any)
    else $error("detected parity flag not visible");

  property p_sticky;
    @(posedge clk) disable iff (srst)
    flags[F_SSE] && !(wr && status_hit && wdata[SSE_BIT])
      |=> flags[F_SSE];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky flag dropped without clear");

  property p_clear;
    @(posedge clk) disable iff (srst)
    wr && status_hit && wdata[RMA_BIT] && !set_ev[F_RMA]
      |=> !flags[F_RMA];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear flag");

  property p_set_wins;
    @(posedge clk) disable iff (srst)
    !reverse_mode && fwd_poisoned_tlp_rx && wr && status_hit &&
      wdata[DPE_BIT] |=> flags[F_DPE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_fwd_sse_dpe;
    @(posedge clk) disable iff (srst)
    !reverse_mode |-> (fwd_err_msg_tx |=> flags[F_SSE]) and
      (fwd_poisoned_tlp_rx |=> flags[F_DPE]);
  endproperty
  a_fwd_sse_dpe: assert property (p_fwd_sse_dpe)
    else $error("forward error or poison flag not set");

  property p_rev_rta_rma;
    @(posedge clk) disable iff (srst)
    reverse_mode |-> (rev_target_abort_rx |=> flags[F_RTA]) and
      (rev_master_abort_rx |=> flags[F_RMA]);
  endproperty
  a_rev_rta_rma: assert property (p_rev_rta_rma)
    else $error("reverse received abort flag not set");

  // Events of the other mode leave every flag alone
  property p_fwd_quiet;
    @(posedge clk) disable iff (srst)
    !reverse_mode && !wr && !fwd_poisoned_cpl_rx && !fwd_poisoned_wr_tx &&
      !fwd_abort_cpl_tx && !fwd_abort_cpl_rx && !fwd_unsupp_cpl_rx &&
      !fwd_err_msg_tx && !fwd_poisoned_tlp_rx |=> flags == $past(flags);
  endproperty
  a_fwd_quiet: assert property (p_fwd_quiet)
    else $error("flag changed without a forward event");

  property p_rev_quiet;
    @(posedge clk) disable iff (srst)
    reverse_mode && !wr && !perr_on_send && !rev_read_parity_err &&
      !rev_split_msg_parity_err && !rev_target_abort_tx &&
      !rev_target_abort_rx && !rev_master_abort_rx && !rev_serr_asserted &&
      !rev_parity_err_det |=> flags == $past(flags);
  endproperty
  a_rev_quiet: assert property (p_rev_quiet)
    else $error("flag changed without a reverse event");

  property p_mode_frozen;
    @(posedge clk) disable iff (srst)
    1'b1 |=> $stable(reverse_mode) && $stable(pci_mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("captured mode changed outside reset");

  property p_rdata_idle;
    @(posedge clk) disable iff (srst)
    !(rd && status_hit) |=> rdata == RDATA_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  c_set_clear: cover property (@(posedge clk) disable iff (srst)
    set_ev[F_DPE] && clr_ev[F_DPE]);
  c_rev_mdpe: cover property (@(posedge clk) disable iff (srst)
    reverse_mode && set_ev[F_MDPE]);
  c_fwd_read: cover property (@(posedge clk) disable iff (srst)
    flags[F_STA] ##1 rd && status_hit);
  c_clear_all: cover property (@(posedge clk) disable iff (srst)
    flags == 6'h3F ##1 flags == 6'h00);
  c_perr_pin: cover property (@(posedge clk) disable iff (srst)
    reverse_mode && perr_on_send && parity_resp_en);
endmodule : bpsf_status
`default_nettype wire

// *** bpsf_pin_model.sv ***
// Host-side model driving the primary parity error pin
`timescale 1ns/10ps
`default_nettype none
module bpsf_pin_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic perr_req,
  output logic primary_parity_error_n
);
  logic [2:0] hold;
  // Pulled up unless an error is being reported
  always_ff @(posedge clk) begin
    if (srst) begin
      hold <= 3'h0;
    end else if (perr_req) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign primary_parity_error_n = (hold == 3'h0);
endmodule : bpsf_pin_model
`default_nettype wire

// *** tb_bridge_primary_status_flags.sv ***
// Testbench for the primary-side status flag bank
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_primary_status_flags;
  import bpsf_pkg::*;
  logic clk, srst, wr, rd, rev_pin, pci_pin, pre, sending, perr_req;
  logic pin_n, rmode;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [6:0] fwd_ev, rev_ev;
  int miscompares = 0;
  int total_checks = 0;
  int bt[7] = '{24, 24, 27, 28, 29, 30, 31};
  localparam logic [DATA_W-1:0] ALL = 32'hFFFFFFFF;
  bpsf_status uut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .reverse_mode_pin(rev_pin),
    .pci_mode_pin(pci_pin), .primary_parity_error_n(pin_n),
    .parity_resp_en(pre), .fwd_poisoned_cpl_rx(fwd_ev[0]),
    .fwd_poisoned_wr_tx(fwd_ev[1]), .fwd_abort_cpl_tx(fwd_ev[2]),
    .fwd_abort_cpl_rx(fwd_ev[3]), .fwd_unsupp_cpl_rx(fwd_ev[4]),
    .fwd_err_msg_tx(fwd_ev[5]), .fwd_poisoned_tlp_rx(fwd_ev[6]),
    .rev_read_parity_err(rev_ev[0]), .rev_sending_data(sending),
    .rev_split_msg_parity_err(rev_ev[1]), .rev_target_abort_tx(rev_ev[2]),
    .rev_target_abort_rx(rev_ev[3]), .rev_master_abort_rx(rev_ev[4]),
    .rev_serr_asserted(rev_ev[5]), .rev_parity_err_det(rev_ev[6]),
    .reverse_mode(rmode));
  bpsf_pin_model host (.clk(clk), .srst(srst), .perr_req(perr_req),
    .primary_parity_error_n(pin_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [DATA_W-1:0] g, e, m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e, m);
  endtask : rd_chk
  task automatic do_reset(input logic r, p);
    @(posedge clk);
    srst <= 1'b1;
    rev_pin <= r;
    pci_pin <= p;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset
  task automatic pulse(input logic fwd, input logic [6:0] v);
    @(posedge clk);
    if (fwd) fwd_ev <= v;
    else rev_ev <= v;
    @(posedge clk);
    fwd_ev <= 7'h00;
    rev_ev <= 7'h00;
  endtask : pulse
  task automatic ev_test(input logic fwd, input logic [DATA_W-1:0] base);
    logic [DATA_W-1:0] b;
    for (int i = 0; i < 7; i++) begin
      b = 32'h00000001 << bt[i];
      pulse(fwd, 7'h01 << i);
      rd_chk(8'h04, base | b, ALL);
      wr_reg(8'h04, 32'h00000000);
      rd_chk(8'h04, base | b, ALL);
      wr_reg(8'h04, 32'hFFFF0000);
      rd_chk(8'h04, base, ALL);
    end
    pulse(!fwd, 7'h7F);
    rd_chk(8'h04, base, ALL);
    @(posedge clk);
    pre <= 1'b0;
    pulse(fwd, 7'h43);
    rd_chk(8'h04, base | 32'h80000000, ALL);
    wr_reg(8'h04, 32'hFFFF0000);
    @(posedge clk);
    pre <= 1'b1;
  endtask : ev_test
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    {wr, rd, rev_pin, pci_pin, sending, perr_req} = 6'h00;
    pre = 1'b1;
    addr = 8'h00;
    wdata = 32'h00000000;
    fwd_ev = 7'h00;
    rev_ev = 7'h00;
    do_reset(1'b0, 1'b0);
    rd_chk(8'h04, 32'h00100000, ALL);
    rd_chk(8'h08, 32'h00000000, ALL);
    wr_reg(8'h04, ALL);
    rd_chk(8'h04, 32'h00100000, ALL);
    ev_test(1'b1, 32'h00100000);
    // Event and write-one clear in the same cycle: the set wins
    @(posedge clk);
    fwd_ev <= 7'h40;
    wr <= 1'b1;
    addr <= 8'h04;
    wdata <= ALL;
    @(posedge clk);
    fwd_ev <= 7'h00;
    wr <= 1'b0;
    rd_chk(8'h04, 32'h80100000, ALL);
    wr_reg(8'h04, ALL);
    rd_chk(8'h04, 32'h00100000, ALL);
    $display("Test forward mode done");
    do_reset(1'b1, 1'b1);
    rd_chk(8'h04, 32'h02B00000, ALL);
    chk({31'h0, rmode}, 32'h00000001, ALL);
    ev_test(1'b0, 32'h02B00000);
    @(posedge clk);
    sending <= 1'b1;
    perr_req <= 1'b1;
    @(posedge clk);
    perr_req <= 1'b0;
    repeat (6) @(posedge clk);
    sending <= 1'b0;
    rd_chk(8'h04, 32'h03B00000, ALL);
    $display("Test reverse PCI mode done");
    do_reset(1'b1, 1'b0);
    rd_chk(8'h04, 32'h02300000, ALL);
    $display("Test reverse non-PCI mode done");
    finish_test();
  end
endmodule : tb_bridge_primary_status_flags
`default_nettype wire
